// ---- src/do_timing_pkg.sv ----
/*
 file holds the shared constants of the digital output timing engine:
 source selects, timing counts, line counts and power-up state codes.
 assumes a 200 MHz system clock; all other rates are enables derived from it.
*/
package do_timing_pkg;
   localparam int unsigned SYS_CLK_HZ       = 200_000_000;
   localparam int unsigned TB_100M_HZ       = 100_000_000;
   localparam int unsigned TB_20M_HZ        = 20_000_000;
   localparam int unsigned TB_100K_HZ       = 100_000;
   localparam int unsigned DIV_100M         = SYS_CLK_HZ / TB_100M_HZ;
   localparam int unsigned DIV_20M          = SYS_CLK_HZ / TB_20M_HZ;
   localparam int unsigned DIV_100K         = SYS_CLK_HZ / TB_100K_HZ;
   localparam int unsigned PRESCALE_W       = 11;
   // change merge window, longest time so rounded down
   localparam int unsigned MERGE_WINDOW_NS  = 50;
   localparam int unsigned SYS_CLK_PERIOD_PS = 5000;
   localparam int unsigned MERGE_CYCLES     = (MERGE_WINDOW_NS * 1000) / SYS_CLK_PERIOD_PS;
   localparam int unsigned MERGE_W          = 4;
   localparam logic [MERGE_W-1:0] MERGE_LAST = MERGE_W'(MERGE_CYCLES - 1);
   // counters and widths
   localparam int unsigned CNT_W            = 32;
   localparam logic [CNT_W-1:0] START_DELAY_DEFAULT = 32'h00000002;
   localparam int unsigned DIG_LINES        = 32;
   localparam int unsigned PFL_LINES        = 16;
   localparam int unsigned CD_LINES         = DIG_LINES + PFL_LINES;
   localparam int unsigned DATA_W           = 32;
   // timebase source select
   localparam logic [1:0] TB_SEL_100M       = 2'h0;
   localparam logic [1:0] TB_SEL_20M        = 2'h1;
   localparam logic [1:0] TB_SEL_100K       = 2'h2;
   localparam logic [1:0] TB_SEL_EXT        = 2'h3;
   // sample clock source select
   localparam logic [1:0] SC_SEL_INTERNAL   = 2'h0;
   localparam logic [1:0] SC_SEL_EXT        = 2'h1;
   localparam logic [1:0] SC_SEL_CHANGE     = 2'h2;
   // start trigger source select
   localparam logic [1:0] ST_SEL_SOFTWARE   = 2'h0;
   localparam logic [1:0] ST_SEL_DIGITAL    = 2'h1;
   localparam logic [1:0] ST_SEL_ANALOG     = 2'h2;
   localparam logic [1:0] ST_SEL_CHANGE     = 2'h3;
   // pause source select
   localparam logic [1:0] PS_SEL_NONE       = 2'h0;
   localparam logic [1:0] PS_SEL_DIGITAL    = 2'h1;
   localparam logic [1:0] PS_SEL_ANALOG     = 2'h2;
   // power-up state per line
   localparam logic [1:0] PU_HIGH_Z         = 2'h0;
   localparam logic [1:0] PU_DRIVE_0        = 2'h1;
   localparam logic [1:0] PU_DRIVE_1        = 2'h2;
   // change edge enable bit positions
   localparam int unsigned CD_RISE_BIT      = 0;
   localparam int unsigned CD_FALL_BIT      = 1;
endpackage

// ---- src/change_detector.sv ----
/*
 file holds the change detector: per-line edge detection on the synchronised
 lines, or-combined and merged into one event per window.
 assumes lines are synchronous to i_clk_sys; i_tb100_en marks 100 MHz ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module change_detector (
   input  wire logic                                 i_clk_sys,
   input  wire logic                                 i_rst_b,
   input  wire logic                                 i_tb100_en,
   input  wire logic [do_timing_pkg::CD_LINES-1:0]   i_lines,
   input  wire logic [do_timing_pkg::CD_LINES-1:0]   i_rise_en,
   input  wire logic [do_timing_pkg::CD_LINES-1:0]   i_fall_en,
   output logic                                      o_change_event,
   output logic [do_timing_pkg::CD_LINES-1:0]        o_changed_lines
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [do_timing_pkg::CD_LINES-1:0] sync_reg;
   logic [do_timing_pkg::CD_LINES-1:0] prev_reg;
   logic [do_timing_pkg::CD_LINES-1:0] hit;
   logic [do_timing_pkg::CD_LINES-1:0] accum_reg;
   logic [do_timing_pkg::MERGE_W-1:0]  win_reg;
   logic                               win_open_reg;
   logic                               any_hit;

   // lines sampled on the 100 MHz tick, then compared with last sample
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_reg <= '0;
         prev_reg <= '0;
      end else if (i_tb100_en) begin
         sync_reg <= i_lines;
         prev_reg <= sync_reg;
      end
   end

   // one detector per line, rise and fall enabled separately
   genvar g;
   generate
      for (g = 0; g < do_timing_pkg::CD_LINES; g++) begin : g_det
         assign hit[g] = i_tb100_en &&
                         ((i_rise_en[g] && sync_reg[g] && !prev_reg[g]) ||
                          (i_fall_en[g] && !sync_reg[g] && prev_reg[g]));
      end
   endgenerate

   assign any_hit = |hit;

   // changes inside one window fold into one event at window close
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         win_open_reg   <= 1'b0;
         win_reg        <= '0;
         accum_reg      <= '0;
         o_change_event <= 1'b0;
         o_changed_lines <= '0;
      end else begin
         o_change_event <= 1'b0;
         if (win_open_reg) begin
            accum_reg <= accum_reg | hit;
            if (win_reg == do_timing_pkg::MERGE_LAST) begin
               win_open_reg    <= 1'b0;
               o_change_event  <= 1'b1;
               o_changed_lines <= accum_reg | hit;
            end else begin
               win_reg <= win_reg + 1'b1;
            end
         end else if (any_hit) begin
            win_open_reg <= 1'b1;
            win_reg      <= '0;
            accum_reg    <= hit;
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/do_timing_engine.sv ----
/*
 file holds the digital output timing engine: timebase select and divide,
 start and pause triggers, finite and retriggerable runs, sample updates,
 power-up line states and the change detection event.
 assumes all inputs synchronous to i_clk_sys; external sources are levels.
*/
// How it works
// - sample clock is internal unless the external or change event source is selected.
// - start launches engine; first sample after delay, default two ticks; hw or sw stop.
// - selected timebase divided into sample clock; 100M default, 20M, 100k, external.
// - timebase is never driven out to a terminal.
// - exported sample clock is active low.
// - with no trigger, software start command begins generation.
// - retriggerable mode repeats the full sequence per start pulse.
// - starts ignored while running; after completion, wait for a new start.
// - digital start begins on selectable rising or falling edge.
// - analog start begins on first selected edge of comparison event.
// - exported start trigger is a high pulse.
// - pause stops new samples; sample in progress completes.
// - onboard clock resumes immediately when pause deasserts.
// - other clock sources resume on the second sample edge after pause ends.
// - digital pause active high or low, software chosen.
// - analog pause active while comparison event is high.
// - lines power up high-z, or drive 0 or 1 as programmed.
// - change detector watches 32 digital and 16 function lines.
// - each line synchronised to 100 MHz, with own rise and fall enables.
// - enabled detectors are or-combined into one event.
// - changes within 50 ns merge into one event.
// - change event can clock output, go to terminals, raise interrupt.
// - each sample edge moves next sample out; empty buffer flags underflow.
// - output update on selectable rising or falling edge of the external sample clock.
`timescale 1ns/1ps
`default_nettype none
module do_timing_engine (
   input  wire logic                                  i_clk_sys,
   input  wire logic                                  i_rst_b,
   // configuration
   input  wire logic [1:0]                            i_tb_sel,
   input  wire logic [1:0]                            i_sc_sel,
   input  wire logic [1:0]                            i_st_sel,
   input  wire logic [1:0]                            i_ps_sel,
   input  wire logic [do_timing_pkg::CNT_W-1:0]       i_sc_divisor,
   input  wire logic                                  i_start_delay_set,
   input  wire logic [do_timing_pkg::CNT_W-1:0]       i_start_delay,
   input  wire logic [do_timing_pkg::CNT_W-1:0]       i_sample_count,
   input  wire logic                                  i_finite_mode,
   input  wire logic                                  i_retrigger_en,
   input  wire logic                                  i_start_falling,
   input  wire logic                                  i_pause_low,
   input  wire logic                                  i_update_falling,
   // commands and sources
   input  wire logic                                  i_sw_start,
   input  wire logic                                  i_sw_stop,
   input  wire logic                                  i_ext_timebase,
   input  wire logic                                  i_ext_sample_clock,
   input  wire logic                                  i_start_source,
   input  wire logic                                  i_analog_event,
   input  wire logic                                  i_pause_source,
   // sample buffer
   input  wire logic                                  i_sample_valid,
   input  wire logic [do_timing_pkg::DATA_W-1:0]      i_sample_data,
   output logic                                       o_sample_ready,
   // lines
   input  wire logic [2*do_timing_pkg::DIG_LINES-1:0] i_dig_powerup,
   input  wire logic [2*do_timing_pkg::PFL_LINES-1:0] i_pfl_powerup,
   input  wire logic [do_timing_pkg::DIG_LINES-1:0]   i_digital_line,
   input  wire logic [do_timing_pkg::PFL_LINES-1:0]   i_programmable_function_line,
   input  wire logic                                  i_wave_out_en,
   output logic [do_timing_pkg::DIG_LINES-1:0]        o_digital_line,
   output logic [do_timing_pkg::DIG_LINES-1:0]        o_digital_line_oe,
   output logic [do_timing_pkg::PFL_LINES-1:0]        o_programmable_function_line,
   output logic [do_timing_pkg::PFL_LINES-1:0]        o_programmable_function_line_oe,
   // change detection
   input  wire logic [do_timing_pkg::CD_LINES-1:0]    i_cd_rise_en,
   input  wire logic [do_timing_pkg::CD_LINES-1:0]    i_cd_fall_en,
   output logic                                       o_change_event,
   output logic [do_timing_pkg::CD_LINES-1:0]         o_changed_lines,
   output logic                                       o_change_irq,
   // status and exports
   output logic                                       o_running,
   output logic                                       o_done,
   output logic                                       o_underflow,
   output logic                                       o_output_sample_clock_b,
   output logic                                       o_output_start_trigger,
   output logic                                       o_output_pause_trigger
);
   ////////////////////////////////////////////////////////////////////////////////
   // timebase prescaler: fixed-rate enables derived from the system clock
   logic [do_timing_pkg::PRESCALE_W-1:0] pre100m_reg;
   logic [do_timing_pkg::PRESCALE_W-1:0] pre20m_reg;
   logic [do_timing_pkg::PRESCALE_W-1:0] pre100k_reg;
   logic tb100_en;
   logic tb20_en;
   logic tb100k_en;
   logic ext_tb_prev_reg;
   logic ext_sc_prev_reg;
   logic tb_tick;
   logic ext_sc_edge;

   function automatic logic wrap(input logic [do_timing_pkg::PRESCALE_W-1:0] c,
                                 input int unsigned d);
      wrap = (c == do_timing_pkg::PRESCALE_W'(d - 1));
   endfunction

   assign tb100_en  = wrap(pre100m_reg, do_timing_pkg::DIV_100M);
   assign tb20_en   = wrap(pre20m_reg, do_timing_pkg::DIV_20M);
   assign tb100k_en = wrap(pre100k_reg, do_timing_pkg::DIV_100K);

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pre100m_reg <= '0;
         pre20m_reg  <= '0;
         pre100k_reg <= '0;
      end else begin
         pre100m_reg <= tb100_en  ? '0 : pre100m_reg + 1'b1;
         pre20m_reg  <= tb20_en   ? '0 : pre20m_reg + 1'b1;
         pre100k_reg <= tb100k_en ? '0 : pre100k_reg + 1'b1;
      end
   end

   // external sources are edge detected so they act as tick enables
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ext_tb_prev_reg <= 1'b0;
         ext_sc_prev_reg <= 1'b0;
      end else begin
         ext_tb_prev_reg <= i_ext_timebase;
         ext_sc_prev_reg <= i_ext_sample_clock;
      end
   end

   // timebase select; it is only used inside, never exported
   always_comb begin
      if (i_tb_sel == do_timing_pkg::TB_SEL_20M) begin
         tb_tick = tb20_en;
      end else if (i_tb_sel == do_timing_pkg::TB_SEL_100K) begin
         tb_tick = tb100k_en;
      end else if (i_tb_sel == do_timing_pkg::TB_SEL_EXT) begin
         tb_tick = i_ext_timebase && !ext_tb_prev_reg;
      end else begin
         tb_tick = tb100_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // change detector on digital and function lines
   logic cd_event;
   change_detector u_cd (
      .i_clk_sys       (i_clk_sys),
      .i_rst_b         (i_rst_b),
      .i_tb100_en      (tb100_en),
      .i_lines         ({i_programmable_function_line, i_digital_line}),
      .i_rise_en       (i_cd_rise_en),
      .i_fall_en       (i_cd_fall_en),
      .o_change_event  (cd_event),
      .o_changed_lines (o_changed_lines)
   );
   assign o_change_event = cd_event;
   assign o_change_irq   = cd_event;

   ////////////////////////////////////////////////////////////////////////////////
   // start trigger and pause qualification
   logic st_prev_reg;
   logic an_prev_reg;
   logic start_pulse;
   logic pause_act;
   logic start_delay_cfg_reg;

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_prev_reg <= 1'b0;
         an_prev_reg <= 1'b0;
      end else begin
         st_prev_reg <= i_start_source;
         an_prev_reg <= i_analog_event;
      end
   end

   always_comb begin
      if (i_st_sel == do_timing_pkg::ST_SEL_DIGITAL) begin
         start_pulse = i_start_falling ? (!i_start_source && st_prev_reg)
                                       : (i_start_source && !st_prev_reg);
      end else if (i_st_sel == do_timing_pkg::ST_SEL_ANALOG) begin
         start_pulse = i_start_falling ? (!i_analog_event && an_prev_reg)
                                       : (i_analog_event && !an_prev_reg);
      end else if (i_st_sel == do_timing_pkg::ST_SEL_CHANGE) begin
         start_pulse = cd_event;
      end else begin
         start_pulse = i_sw_start;
      end
   end

   always_comb begin
      if (i_ps_sel == do_timing_pkg::PS_SEL_DIGITAL) begin
         pause_act = i_pause_low ? !i_pause_source : i_pause_source;
      end else if (i_ps_sel == do_timing_pkg::PS_SEL_ANALOG) begin
         pause_act = i_analog_event;
      end else begin
         pause_act = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // run state machine
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DELAY = 3'b010,
      ST_RUN   = 3'b100
   } run_state_t;
   run_state_t state_reg;

   logic [do_timing_pkg::CNT_W-1:0] delay_reg;
   logic [do_timing_pkg::CNT_W-1:0] div_reg;
   logic [do_timing_pkg::CNT_W-1:0] done_cnt_reg;
   logic [do_timing_pkg::CNT_W-1:0] delay_load;
   logic                            resume_wait_reg;
   logic                            int_sc;
   logic                            sc_edge;
   logic                            sample_fire;
   logic                            last_sample;

   // delay defaults to two ticks until software programs its own value
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         start_delay_cfg_reg <= 1'b0;
      end else if (i_start_delay_set) begin
         start_delay_cfg_reg <= 1'b1;
      end
   end
   assign delay_load = start_delay_cfg_reg ? i_start_delay
                                           : do_timing_pkg::START_DELAY_DEFAULT;

   assign int_sc = tb_tick && (div_reg == '0);
   assign ext_sc_edge = i_update_falling ? (!i_ext_sample_clock && ext_sc_prev_reg)
                                         : (i_ext_sample_clock && !ext_sc_prev_reg);
   always_comb begin
      if (i_sc_sel == do_timing_pkg::SC_SEL_EXT) begin
         sc_edge = ext_sc_edge;
      end else if (i_sc_sel == do_timing_pkg::SC_SEL_CHANGE) begin
         sc_edge = cd_event;
      end else begin
         sc_edge = int_sc;
      end
   end

   // pause checked at sample boundaries only, so a started sample completes
   assign sample_fire = (state_reg == ST_RUN) && sc_edge && !pause_act
                        && !resume_wait_reg;
   assign last_sample = i_finite_mode && (done_cnt_reg + 1'b1 >= i_sample_count);

   // non-onboard clocks swallow the first edge after pause ends
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         resume_wait_reg <= 1'b0;
      end else if (state_reg != ST_RUN) begin
         resume_wait_reg <= 1'b0;
      end else if (pause_act) begin
         resume_wait_reg <= (i_sc_sel != do_timing_pkg::SC_SEL_INTERNAL);
      end else if (sc_edge) begin
         resume_wait_reg <= 1'b0;
      end
   end

   // internal sample divider restarts at the run start; holds while paused
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_reg <= '0;
      end else if (state_reg != ST_RUN) begin
         div_reg <= '0;
      end else if (tb_tick && !pause_act) begin
         div_reg <= (div_reg + 1'b1 >= i_sc_divisor) ? '0 : div_reg + 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg    <= ST_IDLE;
         delay_reg    <= '0;
         done_cnt_reg <= '0;
         o_done       <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start_pulse && (i_retrigger_en || !o_done || i_sw_start)) begin
                  state_reg    <= ST_DELAY;
                  delay_reg    <= delay_load;
                  done_cnt_reg <= '0;
                  o_done       <= 1'b0;
               end else if (i_sw_start) begin
                  o_done <= 1'b0; // software re-arms a one-shot engine
               end
            end
            ST_DELAY: begin
               if (i_sw_stop) begin
                  state_reg <= ST_IDLE;
               end else if (tb_tick) begin
                  if (delay_reg <= 32'h00000001) begin
                     state_reg <= ST_RUN;
                  end else begin
                     delay_reg <= delay_reg - 1'b1;
                  end
               end
            end
            ST_RUN: begin
               // start pulses are not looked at while running
               if (i_sw_stop) begin
                  state_reg <= ST_IDLE;
                  o_done    <= 1'b1;
               end else if (sample_fire) begin
                  done_cnt_reg <= done_cnt_reg + 1'b1;
                  if (last_sample) begin
                     state_reg <= ST_IDLE;
                     o_done    <= 1'b1;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
   assign o_running = (state_reg != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////////
   // sample transfer, underflow flag and exported strobes
   logic [do_timing_pkg::DATA_W-1:0] wave_reg;
   assign o_sample_ready = sample_fire;

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wave_reg    <= '0;
         o_underflow <= 1'b0;
      end else begin
         if (sample_fire && i_sample_valid) begin
            wave_reg <= i_sample_data;
         end
         if (sample_fire && !i_sample_valid) begin
            o_underflow <= 1'b1;
         end else if (i_sw_start) begin
            o_underflow <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_output_sample_clock_b <= 1'b1;
         o_output_start_trigger  <= 1'b0;
         o_output_pause_trigger  <= 1'b0;
      end else begin
         o_output_sample_clock_b <= !sample_fire;
         o_output_start_trigger  <= start_pulse && (state_reg == ST_IDLE);
         o_output_pause_trigger  <= pause_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // line drive: power-up state until waveform output takes the digital lines
   genvar gl;
   generate
      for (gl = 0; gl < do_timing_pkg::DIG_LINES; gl++) begin : g_dig
         logic [1:0] pu;
         assign pu = i_dig_powerup[2*gl +: 2];
         assign o_digital_line[gl] = i_wave_out_en ? wave_reg[gl]
                                     : (pu == do_timing_pkg::PU_DRIVE_1);
         assign o_digital_line_oe[gl] = i_wave_out_en || (pu != do_timing_pkg::PU_HIGH_Z);
      end
      for (gl = 0; gl < do_timing_pkg::PFL_LINES; gl++) begin : g_pfl
         logic [1:0] pu;
         assign pu = i_pfl_powerup[2*gl +: 2];
         assign o_programmable_function_line[gl] = (pu == do_timing_pkg::PU_DRIVE_1);
         assign o_programmable_function_line_oe[gl] = (pu != do_timing_pkg::PU_HIGH_Z);
      end
   endgenerate
endmodule
`default_nettype wire

// ---- verif/do_timing_engine_checker.sv ----
/* port assertions for the timing engine
   bound into every do_timing_engine instance */
`timescale 1ns/1ps
`default_nettype none
module do_timing_engine_checker (
   input wire logic       i_clk_sys, i_rst_b, i_sw_start, i_sample_valid,
   input wire logic [1:0] i_st_sel,
   input wire logic       o_running, o_done, o_sample_ready, o_underflow,
   input wire logic       o_output_sample_clock_b, o_output_start_trigger,
   input wire logic       o_change_event, o_change_irq,
   input wire logic [do_timing_pkg::CD_LINES-1:0] o_changed_lines
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   AST_SCLK_LOW: assert property (o_sample_ready |=> !o_output_sample_clock_b)
      else $error("sample clock not low");
   AST_SCLK_CAUSE: assert property ($fell(o_output_sample_clock_b) |-> $past(o_sample_ready))
      else $error("stray sample clock");
   AST_SW_START: assert property (i_sw_start && i_st_sel == 2'h0 && !o_running |=> o_running)
      else $error("software start lost");
   AST_UFLOW: assert property (o_sample_ready && !i_sample_valid |=> o_underflow)
      else $error("underflow missed");
   AST_DONE_IDLE: assert property (o_done |-> !o_running)
      else $error("done while running");
   AST_TRIG_PULSE: assert property (o_output_start_trigger |=> !o_output_start_trigger)
      else $error("start export too long");
   AST_IRQ: assert property (o_change_irq == o_change_event)
      else $error("irq not with event");
   AST_MERGE: assert property (o_change_event |=> !o_change_event [*8])
      else $error("events too close");
   AST_EVENT_LINES: assert property (o_change_event |-> o_changed_lines != '0)
      else $error("event with no line");
endmodule
bind do_timing_engine do_timing_engine_checker u_chk (.*);
`default_nettype wire

// ---- verif/start_source_model.sv ----
/* far-side start source: four two-clock pulses four clocks apart after i_go
   assumes i_go is a one-clock pulse */
`timescale 1ns/1ps
`default_nettype none
module start_source_model (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_b,
   input  wire logic i_go,
   output logic      o_start_source
);
   logic [3:0] step_reg;
   // later edges land mid-run, so an engine that re-arms early shows it
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         step_reg <= 4'h0;
         o_start_source <= 1'b0;
      end else begin
         step_reg <= i_go ? 4'h1 : (step_reg != 4'h0 ? step_reg + 4'h1 : 4'h0);
         o_start_source <= step_reg[1];
      end
   end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
/* self-checking bench for the timing engine
   inputs change at rising edges; results are judged at falling edges, the underflow, events and changed checks at rising ones */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic [1:0] i_tb_sel, i_sc_sel, i_st_sel, i_ps_sel;
   logic [31:0] i_sc_divisor, i_start_delay, i_sample_count, i_sample_data, i_digital_line,
                i_pfl_powerup, o_digital_line, o_digital_line_oe, exp;
   logic i_clk_sys = 0, i_rst_b = 0, go = 0, chk_next = 0, i_start_delay_set, i_finite_mode,
         i_retrigger_en, i_start_falling, i_pause_low, i_update_falling, i_sw_start, i_sw_stop,
         i_ext_timebase, i_ext_sample_clock, i_start_source, i_analog_event, i_pause_source,
         i_sample_valid, i_wave_out_en, o_sample_ready, o_change_event, o_change_irq,
         o_running, o_done, o_underflow, o_output_sample_clock_b, o_output_start_trigger,
         o_output_pause_trigger;
   logic [63:0] i_dig_powerup;
   logic [15:0] i_programmable_function_line, o_programmable_function_line,
                o_programmable_function_line_oe;
   logic [47:0] i_cd_rise_en, i_cd_fall_en, o_changed_lines;
   int bad_count = 0, compares = 0, seed = 32'h037b7124, fired = 0, events = 0;
   do_timing_engine u_do_timing_engine (.*);
   start_source_model u_start_source_model (.i_clk_sys, .i_rst_b, .i_go(go),
                                            .o_start_source(i_start_source));
   initial forever #2.5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) i_sample_data <= $random(seed);
   task automatic check(string what, logic [63:0] seen, logic [63:0] want);
      compares++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // reference model: a taken sample shows on the lines one clock later
   always @(negedge i_clk_sys) begin
      if (chk_next) check("lines", o_digital_line, exp);
      chk_next = o_sample_ready && i_sample_valid;
      if (o_sample_ready) fired++;
      if (o_sample_ready) exp = i_sample_data;
      if (o_change_event) events++;
   end
   // one finite run; a hang past the bound ends the simulation as a mismatch
   task automatic run(int t, logic sw);
      int k;
      fired = 0;
      i_sw_start <= sw;
      go <= !sw;
      @(posedge i_clk_sys);
      i_sw_start <= 0;
      go <= 0;
      repeat (8) @(posedge i_clk_sys);
      for (k = 0; k < 400 && o_done !== 1'b1; k++) @(posedge i_clk_sys);
      if (k == 400) begin
         bad_count++;
         summarize();
      end
      @(negedge i_clk_sys);
      check("samples", fired, 6);
      $display("test %0d over", t);
      @(posedge i_clk_sys);
   endtask
   initial begin
      {i_tb_sel, i_sc_sel, i_st_sel, i_ps_sel, i_start_delay_set, i_start_delay,
       i_start_falling, i_pause_low, i_update_falling, i_sw_start, i_sw_stop, i_ext_timebase,
       i_ext_sample_clock, i_analog_event, i_pause_source, i_pfl_powerup, i_digital_line,
       i_programmable_function_line, i_cd_fall_en, i_wave_out_en, i_retrigger_en} = '0;
      {i_sc_divisor, i_sample_count, i_finite_mode, i_sample_valid} = {32'h1, 32'h6, 2'h3};
      i_cd_rise_en = '1;
      for (int i = 0; i < 32; i++) i_dig_powerup[2*i+:2] = 2'({$random(seed)} % 3);
      repeat (3) @(posedge i_clk_sys);
      i_rst_b <= 1;
      @(negedge i_clk_sys);
      for (int i = 0; i < 32; i++) begin
         check("oe", o_digital_line_oe[i], i_dig_powerup[2*i+:2] != 0);
         check("pin", o_digital_line[i] & o_digital_line_oe[i], i_dig_powerup[2*i+:2] == 2);
      end
      check("pfl", {o_programmable_function_line_oe, o_programmable_function_line}, 0);
      @(posedge i_clk_sys);
      i_wave_out_en <= 1;
      run(1, 1);
      {i_st_sel, i_retrigger_en} <= 3'h3;
      run(2, 0);
      i_start_falling <= 1;
      run(3, 0);
      {i_st_sel, i_sample_valid} <= 3'h0;
      run(4, 1);
      check("underflow", o_underflow, 1);
      events = 0;
      i_digital_line <= 32'h1;
      repeat (2) @(posedge i_clk_sys);
      i_digital_line <= 32'h3;
      repeat (30) @(posedge i_clk_sys);
      check("events", events, 1);
      check("changed", o_changed_lines, 48'h3);
      $display("test 5 over");
      summarize();
   end
endmodule
`default_nettype wire
